//--- aphc_pkg.sv
// Shared constants and types for the address unit hazard control block
// ==========================================================================
package aphc_pkg;
    // ======================================================================
    // Register map, byte addresses
    localparam logic [7:0]  OFF_PC     = 8'h00;
    localparam logic [7:0]  OFF_SR     = 8'h04;
    localparam logic [7:0]  OFF_LA     = 8'h08;
    localparam logic [7:0]  OFF_LC     = 8'h0c;
    localparam logic [7:0]  OFF_OMR    = 8'h10;
    localparam logic [7:0]  OFF_LSTK   = 8'h14;
    localparam logic [7:0]  OFF_HZST   = 8'h18;
    localparam logic [7:0]  OFF_CTRL   = 8'h1c;
    localparam logic [7:0]  OFF_STCNT  = 8'h20;
    // ======================================================================
    // Field positions and reset values
    localparam int          LF_BIT     = 9;
    localparam int          NL_BIT     = 15;
    localparam int          HZ_W       = 3;
    localparam int          HZ_PTR     = 0;
    localparam int          HZ_BFOFF   = 1;
    localparam int          HZ_SPCALL  = 2;
    localparam int          CTRL_ILOCK = 0;
    localparam logic [15:0] SR_RESET   = 16'h0000;
    localparam logic [15:0] OMR_RESET  = 16'h0000;
    localparam logic [15:0] CTRL_RESET = 16'h0001;
    // ======================================================================
    // Register codes on the decode port
    localparam logic [3:0]  REG_PTR1   = 4'h1;
    localparam logic [3:0]  REG_OFFSET = 4'h4;
    localparam logic [3:0]  REG_STACK  = 4'h5;
    localparam logic [3:0]  REG_MODULO = 4'h6;
    localparam logic [3:0]  REG_STATUS = 4'h7;
    localparam logic [3:0]  REG_NONE   = 4'hf;
    // ======================================================================
    // Decode classes and modes
    typedef enum logic [2:0] {
        MODE_NONE    = 3'h0,
        MODE_NOUPD   = 3'h1,
        MODE_POSTINC = 3'h2,
        MODE_POSTDEC = 3'h3,
        MODE_POSTN   = 3'h4,
        MODE_IDXN    = 3'h5,
        MODE_IDXIMM  = 3'h6
    } aphc_mode_t;
    typedef enum logic [2:0] {
        CLS_OTHER  = 3'h0,
        CLS_MOVE   = 3'h1,
        CLS_BFMOD  = 3'h2,
        CLS_BFTEST = 3'h3,
        CLS_BITBR  = 3'h4,
        CLS_LOOP   = 3'h5,
        CLS_CALL   = 3'h6
    } aphc_class_t;
    typedef enum logic [1:0] {
        BF_SET = 2'h0,
        BF_CLR = 2'h1,
        BF_CHG = 2'h2
    } aphc_bfop_t;
endpackage

//--- aphc_hazard_ctrl.sv
// Address unit interlock, status modify sequencing and loop control
`timescale 1ns/100ps
module aphc_hazard_ctrl #(
    parameter int LOOP_CNT_W  = 13,
    parameter int STACK_DEPTH = 2
) (
    // Clock and reset
    input  logic                      clock,
    input  logic                      rst_n,
    // Wishbone slave
    input  logic                      wb_cyc_i,
    input  logic                      wb_stb_i,
    input  logic                      wb_we_i,
    input  logic [7:0]                wb_adr_i,
    input  logic [31:0]               wb_dat_i,
    input  logic [3:0]                wb_sel_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    // Decode stage
    input  logic                      decValid,
    input  aphc_pkg::aphc_class_t     decClass,
    input  aphc_pkg::aphc_mode_t      decMode,
    input  logic [3:0]                decAddrReg,
    input  logic [3:0]                decWrDest,
    input  aphc_pkg::aphc_bfop_t      decBfOp,
    input  logic [15:0]               decBfMask,
    input  logic [LOOP_CNT_W-1:0]     decLoopCount,
    input  logic [15:0]               decLoopEnd,
    input  logic [15:0]               decLoopTop,
    // Fetch stage
    input  logic                      fetchValid,
    input  logic [15:0]               fetchPc,
    // Pipeline control
    output logic                      stall,
    output logic                      loopActive,
    output logic                      loopBranch,
    output logic [15:0]               loopTarget
);
    localparam int DEPTH_W = $clog2(STACK_DEPTH + 1);

    if (LOOP_CNT_W < 1 || LOOP_CNT_W > 16 || STACK_DEPTH < 2) begin : g_bad_param
        $error("aphc_hazard_ctrl: unsupported parameter value");
    end

    // ======================================================================
    // Declarations
    logic [3:0]            lastDest_r,   lastDestNxt;
    logic                  lastBf_r,     lastBfNxt;
    logic [aphc_pkg::HZ_W-1:0] hz_r,     hzNxt;
    logic [15:0]           stCnt_r,      stCntNxt;
    logic [15:0]           sr_r,         srNxt;
    logic [15:0]           la_r,         laNxt;
    logic [LOOP_CNT_W-1:0] lc_r,         lcNxt;
    logic [15:0]           omr_r,        omrNxt;
    logic [15:0]           ctrl_r,       ctrlNxt;
    logic [15:0]           pc_r,         pcNxt;
    logic [15:0]           stk_r [STACK_DEPTH];
    logic [15:0]           stkNxt [STACK_DEPTH];
    logic [DEPTH_W-1:0]    depth_r,      depthNxt;
    logic                  bf1_r,        bf1Nxt;
    logic                  bf2_r,        bf2Nxt;
    logic [15:0]           bfMask_r,     bfMaskNxt;
    aphc_pkg::aphc_bfop_t  bfOp_r,       bfOpNxt;
    logic [15:0]           bfRes_r,      bfResNxt;
    logic                  doPend_r,     doPendNxt;
    logic [LOOP_CNT_W-1:0] doCount_r,    doCountNxt;
    logic [15:0]           doEnd_r,      doEndNxt;
    logic [15:0]           doTop_r,      doTopNxt;
    logic                  branch_r,     branchNxt;
    logic [15:0]           target_r,     targetNxt;
    logic                  ack_r,        ackNxt;
    logic [15:0]           dat_r,        datNxt;
    logic                  accept;
    logic                  usesArith;
    logic                  usesOffset;
    logic                  ilockEn;
    logic                  busReq;
    logic                  busWr;
    logic                  endHit;
    logic                  push;
    logic                  pop;
    logic [15:0]           pushVal;
    logic [15:0]           rdData;
    logic [7:0]            addr;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
        merge16 = old;
        if (sel[0]) begin
            merge16[7:0] = d[7:0];
        end
        if (sel[1]) begin
            merge16[15:8] = d[15:8];
        end
    endfunction

    function automatic logic [15:0] bfApply(input logic [15:0] v, input logic [15:0] m,
                                            input aphc_pkg::aphc_bfop_t op);
        case (op)
            aphc_pkg::BF_SET: bfApply = v | m;
            aphc_pkg::BF_CLR: bfApply = v & ~m;
            default:          bfApply = v ^ m;
        endcase
    endfunction

    // ======================================================================
    // Hazard detection
    assign ilockEn    = ctrl_r[aphc_pkg::CTRL_ILOCK];
    // Indexed immediate and plain moves take no part
    assign usesArith  = decMode inside {aphc_pkg::MODE_NOUPD, aphc_pkg::MODE_POSTINC,
                                        aphc_pkg::MODE_POSTDEC, aphc_pkg::MODE_POSTN,
                                        aphc_pkg::MODE_IDXN};
    // Any base, stack included, post-update or indexed
    assign usesOffset = decMode == aphc_pkg::MODE_POSTN || decMode == aphc_pkg::MODE_IDXN;
    // Only a plain offset write followed by an offset use holds decode
    assign stall      = ilockEn && decValid && usesOffset && !lastBf_r
                        && lastDest_r == aphc_pkg::REG_OFFSET;
    assign accept     = decValid && !stall;
    assign addr       = {wb_adr_i[7:2], 2'b00};
    assign busReq     = wb_cyc_i && wb_stb_i;
    assign busWr      = busReq && wb_we_i && ack_r;

    always_comb begin
        lastDestNxt = aphc_pkg::REG_NONE;
        lastBfNxt   = 1'b0;
        // Tests and bit branches write nothing, so they leave no trace
        if (accept && (decClass == aphc_pkg::CLS_MOVE || decClass == aphc_pkg::CLS_BFMOD)) begin
            lastDestNxt = decWrDest;
            lastBfNxt   = decClass == aphc_pkg::CLS_BFMOD;
        end
        hzNxt = hz_r;
        if (busWr && addr == aphc_pkg::OFF_HZST && wb_sel_i[0]) begin
            hzNxt = hz_r & ~wb_dat_i[aphc_pkg::HZ_W-1:0];
        end
        // Unprotected sequences are only recorded; set beats clear
        if (accept && usesArith && lastDest_r == decAddrReg) begin
            hzNxt[aphc_pkg::HZ_PTR] = 1'b1;
        end
        if (accept && usesArith && lastDest_r == aphc_pkg::REG_MODULO
            && decAddrReg <= aphc_pkg::REG_PTR1) begin
            hzNxt[aphc_pkg::HZ_PTR] = 1'b1;
        end
        if (accept && usesOffset && lastBf_r && lastDest_r == aphc_pkg::REG_OFFSET) begin
            hzNxt[aphc_pkg::HZ_BFOFF] = 1'b1;
        end
        if (accept && decClass == aphc_pkg::CLS_CALL && lastDest_r == aphc_pkg::REG_STACK) begin
            hzNxt[aphc_pkg::HZ_SPCALL] = 1'b1;
        end
        stCntNxt = (busWr && addr == aphc_pkg::OFF_STCNT) ? 16'h0000 : stCnt_r;
        stCntNxt = stCntNxt + {15'h0000, stall};
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lastDest_r <= aphc_pkg::REG_NONE;
            lastBf_r   <= 1'b0;
            hz_r       <= '0;
            stCnt_r    <= 16'h0000;
        end else begin
            lastDest_r <= lastDestNxt;
            lastBf_r   <= lastBfNxt;
            hz_r       <= hzNxt;
            stCnt_r    <= stCntNxt;
        end
    end

    // ======================================================================
    // Register read mux
    always_comb begin
        case (addr)
            aphc_pkg::OFF_PC:    rdData = pc_r;
            aphc_pkg::OFF_SR:    rdData = sr_r;
            aphc_pkg::OFF_LA:    rdData = la_r;
            aphc_pkg::OFF_LC:    rdData = 16'(lc_r);
            aphc_pkg::OFF_OMR:   rdData = omr_r;
            aphc_pkg::OFF_LSTK:  rdData = stk_r[0];
            aphc_pkg::OFF_HZST:  rdData = 16'(hz_r);
            aphc_pkg::OFF_CTRL:  rdData = ctrl_r;
            aphc_pkg::OFF_STCNT: rdData = stCnt_r;
            default:             rdData = 16'h0000;
        endcase
    end

    // ======================================================================
    // Program controller state
    assign endHit = sr_r[aphc_pkg::LF_BIT] && fetchValid && fetchPc == la_r && !doPend_r;

    always_comb begin
        srNxt      = sr_r;
        laNxt      = la_r;
        lcNxt      = lc_r;
        omrNxt     = omr_r;
        ctrlNxt    = ctrl_r;
        depthNxt   = depth_r;
        stkNxt     = stk_r;
        bfMaskNxt  = bfMask_r;
        bfOpNxt    = bfOp_r;
        bfResNxt   = bfRes_r;
        doCountNxt = doCount_r;
        doEndNxt   = doEnd_r;
        doTopNxt   = doTop_r;
        targetNxt  = target_r;
        branchNxt  = 1'b0;
        push       = 1'b0;
        pop        = 1'b0;
        pushVal    = doTop_r;
        ackNxt     = busReq && !ack_r;
        datNxt     = (busReq && !ack_r) ? rdData : dat_r;
        pcNxt      = fetchValid ? fetchPc : pc_r;
        bf1Nxt     = accept && decClass == aphc_pkg::CLS_BFMOD && decWrDest == aphc_pkg::REG_STATUS;
        bf2Nxt     = bf1_r;
        doPendNxt  = accept && decClass == aphc_pkg::CLS_LOOP;
        if (bf1Nxt) begin
            bfMaskNxt = decBfMask;
            bfOpNxt   = decBfOp;
        end
        if (doPendNxt) begin
            doCountNxt = decLoopCount;
            doEndNxt   = decLoopEnd;
            doTopNxt   = decLoopTop;
        end
        // First execute cycle samples the status word
        if (bf1_r) begin
            bfResNxt = bfApply(sr_r, bfMask_r, bfOp_r);
        end
        if (busWr) begin
            case (addr)
                aphc_pkg::OFF_SR:   srNxt   = merge16(sr_r, wb_dat_i, wb_sel_i);
                aphc_pkg::OFF_LA:   laNxt   = merge16(la_r, wb_dat_i, wb_sel_i);
                aphc_pkg::OFF_LC:   lcNxt   = LOOP_CNT_W'(merge16(16'(lc_r), wb_dat_i, wb_sel_i));
                aphc_pkg::OFF_OMR:  omrNxt  = merge16(omr_r, wb_dat_i, wb_sel_i);
                aphc_pkg::OFF_CTRL: ctrlNxt = merge16(ctrl_r, wb_dat_i, wb_sel_i);
                aphc_pkg::OFF_LSTK: begin
                    push    = 1'b1;
                    pushVal = merge16(stk_r[0], wb_dat_i, wb_sel_i);
                end
                default: ;
            endcase
        end
        if (endHit) begin
            if (lc_r != LOOP_CNT_W'(1)) begin
                lcNxt     = lc_r - 1'b1;
                branchNxt = 1'b1;
                targetNxt = stk_r[0];
            end else begin
                srNxt[aphc_pkg::LF_BIT] = omr_r[aphc_pkg::NL_BIT];
                pop = 1'b1;
            end
        end
        // Cycle after loop decode raises the flag and saves the outer one
        if (doPend_r) begin
            srNxt[aphc_pkg::LF_BIT]  = 1'b1;
            omrNxt[aphc_pkg::NL_BIT] = sr_r[aphc_pkg::LF_BIT];
            laNxt   = doEnd_r;
            lcNxt   = doCount_r;
            push    = 1'b1;
            pushVal = doTop_r;
        end
        // Second execute cycle writes back; a stale copy overrides the loop set
        if (bf2_r) begin
            srNxt = bfRes_r;
        end
        // Flag dropped in a cycle without an end-address hit still ends the loop
        if (sr_r[aphc_pkg::LF_BIT] && !srNxt[aphc_pkg::LF_BIT] && !endHit) begin
            pop = 1'b1;
        end
        if (push && !pop) begin
            stkNxt[0] = pushVal;
            for (int i = 1; i < STACK_DEPTH; i++) begin
                stkNxt[i] = stk_r[i-1];
            end
            if (depth_r != DEPTH_W'(STACK_DEPTH)) begin
                depthNxt = depth_r + 1'b1;
            end
        end else if (pop && !push) begin
            for (int i = 0; i < STACK_DEPTH - 1; i++) begin
                stkNxt[i] = stk_r[i+1];
            end
            if (depth_r != '0) begin
                depthNxt = depth_r - 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sr_r      <= aphc_pkg::SR_RESET;
            la_r      <= 16'h0000;
            lc_r      <= '0;
            omr_r     <= aphc_pkg::OMR_RESET;
            ctrl_r    <= aphc_pkg::CTRL_RESET;
            pc_r      <= 16'h0000;
            stk_r     <= '{default: 16'h0000};
            depth_r   <= '0;
            bf1_r     <= 1'b0;
            bf2_r     <= 1'b0;
            bfMask_r  <= 16'h0000;
            bfOp_r    <= aphc_pkg::BF_SET;
            bfRes_r   <= 16'h0000;
            doPend_r  <= 1'b0;
            doCount_r <= '0;
            doEnd_r   <= 16'h0000;
            doTop_r   <= 16'h0000;
            branch_r  <= 1'b0;
            target_r  <= 16'h0000;
            ack_r     <= 1'b0;
            dat_r     <= 16'h0000;
        end else begin
            sr_r      <= srNxt;
            la_r      <= laNxt;
            lc_r      <= lcNxt;
            omr_r     <= omrNxt;
            ctrl_r    <= ctrlNxt;
            pc_r      <= pcNxt;
            stk_r     <= stkNxt;
            depth_r   <= depthNxt;
            bf1_r     <= bf1Nxt;
            bf2_r     <= bf2Nxt;
            bfMask_r  <= bfMaskNxt;
            bfOp_r    <= bfOpNxt;
            bfRes_r   <= bfResNxt;
            doPend_r  <= doPendNxt;
            doCount_r <= doCountNxt;
            doEnd_r   <= doEndNxt;
            doTop_r   <= doTopNxt;
            branch_r  <= branchNxt;
            target_r  <= targetNxt;
            ack_r     <= ackNxt;
            dat_r     <= datNxt;
        end
    end

    assign wb_ack_o   = ack_r;
    assign wb_dat_o   = {16'h0000, dat_r};
    assign loopActive = sr_r[aphc_pkg::LF_BIT];
    assign loopBranch = branch_r;
    assign loopTarget = target_r;

    // ======================================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_stall_single: assert property (stall |=> !stall)
        else $error("stall held more than one cycle");
    a_stall_cause: assert property (accept && decClass == aphc_pkg::CLS_MOVE
        && decWrDest == aphc_pkg::REG_OFFSET ##1 decValid && usesOffset && ilockEn |-> stall)
        else $error("offset hazard not stalled");
    a_unused_free: assert property ($past(accept) && decValid && !usesOffset |-> !stall)
        else $error("stall without offset use");
    a_move_free: assert property (decMode == aphc_pkg::MODE_NONE |-> !stall)
        else $error("stall on plain move source");
    a_imm_free: assert property (decMode == aphc_pkg::MODE_IDXIMM |-> !stall)
        else $error("stall on indexed immediate");
    a_test_free: assert property (accept && decClass inside {aphc_pkg::CLS_BFTEST,
        aphc_pkg::CLS_BITBR} |=> !stall)
        else $error("stall after bit test");
    a_bf_write: assert property (bf1_r |-> ##2 sr_r == $past(bfResNxt, 2))
        else $error("status modify written in wrong cycle");
    a_stale_wins: assert property (bf2_r && doPend_r && !bfRes_r[aphc_pkg::LF_BIT]
        |=> !loopActive)
        else $error("loop set not overridden by write-back");
    a_do_sets: assert property (doPend_r && !bf2_r |=> loopActive)
        else $error("loop decode did not raise flag");
    a_flag_ends: assert property (!loopActive |=> !loopBranch)
        else $error("loop branch with flag clear");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    c_stall: cover property (stall ##1 accept);
    c_bf_do: cover property (bf2_r && doPend_r);
    c_branch: cover property (loopBranch);
    c_bus_wr: cover property (busWr && addr == aphc_pkg::OFF_CTRL);
endmodule

//--- aphc_pipe_model.sv
// Fetch and decode stage model that feeds the hazard control block
`timescale 1ns/100ps
module aphc_pipe_model (
    // Clock and interlock
    input  logic                  clock,
    input  logic                  stall,
    // Decode stage
    output logic                  decValid,
    output aphc_pkg::aphc_class_t decClass,
    output aphc_pkg::aphc_mode_t  decMode,
    output logic [3:0]            decAddrReg,
    output logic [3:0]            decWrDest,
    output aphc_pkg::aphc_bfop_t  decBfOp,
    output logic [15:0]           decBfMask,
    output logic [12:0]           decLoopCount,
    output logic [15:0]           decLoopEnd,
    output logic [15:0]           decLoopTop,
    // Fetch stage
    output logic                  fetchValid,
    output logic [15:0]           fetchPc
);
    initial begin
        {decValid, fetchValid, decAddrReg, decBfMask, decLoopCount, decLoopEnd, decLoopTop, fetchPc} = '0;
        decClass = aphc_pkg::CLS_OTHER;
        decMode = aphc_pkg::MODE_NONE;
        decWrDest = aphc_pkg::REG_NONE;
        decBfOp = aphc_pkg::BF_SET;
    end
    task automatic setOps(input aphc_pkg::aphc_bfop_t op, input logic [15:0] m, input logic [12:0] c,
                          input logic [15:0] e, input logic [15:0] t);
        decBfOp <= op;
        decBfMask <= m;
        decLoopCount <= c;
        decLoopEnd <= e;
        decLoopTop <= t;
    endtask
    // Instruction held until an edge without stall
    task automatic issue(input aphc_pkg::aphc_class_t c, input aphc_pkg::aphc_mode_t m,
                         input logic [3:0] a, input logic [3:0] d, output int n);
        logic s;
        n = 0;
        decValid <= 1'b1;
        decClass <= c;
        decMode <= m;
        decAddrReg <= a;
        decWrDest <= d;
        forever begin
            @(negedge clock);
            s = stall;
            @(posedge clock);
            if (s === 1'b0) break;
            n++;
        end
    endtask
    // A gap keeps code clear of unstalled hazards
    task automatic idle(input int n);
        decValid <= 1'b0;
        decWrDest <= ~aphc_pkg::REG_PTR1;
        repeat (n) @(posedge clock);
    endtask
    task automatic fetch(input logic [15:0] pc);
        fetchValid <= 1'b1;
        fetchPc <= pc;
        @(posedge clock);
        fetchValid <= 1'b0;
        fetchPc <= ~pc;
    endtask
endmodule

//--- tb_aphc_hazard_ctrl.sv
// Self-checking bench for the address unit hazard control block
`timescale 1ns/100ps
module tb_aphc_hazard_ctrl;
    // ======================================================================
    // Signals
    logic clock = 0, rst_n = 0, cyc, stb, we, ack, stall, loopActive, loopBranch;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, rd;
    logic [3:0]  sel;
    logic [15:0] loopTarget, fetchPc, lEnd, lTop;
    logic [12:0] lCnt;
    logic [15:0] bfMask;
    logic [3:0]  aReg, wDest;
    logic        dValid, fValid;
    aphc_pkg::aphc_class_t cls;
    aphc_pkg::aphc_mode_t  mode;
    aphc_pkg::aphc_bfop_t  bfOp;
    int failCount = 0, numChecks = 0, cycCount = 0, n;
    always #20 clock = ~clock;
    aphc_pipe_model pm (.clock(clock), .stall(stall), .decValid(dValid), .decClass(cls), .decMode(mode),
        .decAddrReg(aReg), .decWrDest(wDest), .decBfOp(bfOp), .decBfMask(bfMask), .decLoopCount(lCnt),
        .decLoopEnd(lEnd), .decLoopTop(lTop), .fetchValid(fValid), .fetchPc(fetchPc));
    aphc_hazard_ctrl dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
        .decValid(dValid), .decClass(cls), .decMode(mode), .decAddrReg(aReg), .decWrDest(wDest),
        .decBfOp(bfOp), .decBfMask(bfMask), .decLoopCount(lCnt), .decLoopEnd(lEnd), .decLoopTop(lTop),
        .fetchValid(fValid), .fetchPc(fetchPc), .stall(stall), .loopActive(loopActive),
        .loopBranch(loopBranch), .loopTarget(loopTarget));
    // ======================================================================
    // Verdict and checks
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        numChecks++;
        if (g !== e) begin
            failCount++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Hangs end here; the whole run needs a few hundred cycles
    always @(posedge clock) begin
        cycCount++;
        if (cycCount == 20000) begin
            failCount++;
            giveVerdict();
        end
    end
    // ======================================================================
    // Wishbone classic single cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        // No fixed latency assumed; the wait ends on ack, or at the bench timeout
        do @(posedge clock); while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    // ======================================================================
    // Scenarios
    task automatic hz(input aphc_pkg::aphc_class_t pc, input logic [3:0] pd, input aphc_pkg::aphc_class_t c,
                      input aphc_pkg::aphc_mode_t m, input logic [3:0] a, input int e);
        pm.idle(2);
        pm.issue(pc, aphc_pkg::MODE_NONE, 4'h0, pd, n);
        pm.issue(c, m, a, aphc_pkg::REG_NONE, n);
        chk("stall cycles", e, n);
    endtask
    task automatic tRegs();
        rdChk("sr reset", aphc_pkg::OFF_SR, 32'h0);
        rdChk("ctrl reset", aphc_pkg::OFF_CTRL, 32'h1);
        wb(1'b1, aphc_pkg::OFF_LC, 32'hffff);
        rdChk("lc width", aphc_pkg::OFF_LC, 32'h1fff);
        wb(1'b1, 8'h3c, 32'h5a5a);
        rdChk("unmapped", 8'h3c, 32'h0);
        wb(1'b1, aphc_pkg::OFF_LA, 32'h1234, 4'h1);
        rdChk("la low lane", aphc_pkg::OFF_LA, 32'h0034);
    endtask
    task automatic tHazards();
        hz(aphc_pkg::CLS_MOVE, aphc_pkg::REG_OFFSET, aphc_pkg::CLS_MOVE, aphc_pkg::MODE_POSTN, 4'h2, 1);
        hz(aphc_pkg::CLS_MOVE, aphc_pkg::REG_OFFSET, aphc_pkg::CLS_MOVE, aphc_pkg::MODE_POSTN, 4'h5, 1);
        hz(aphc_pkg::CLS_MOVE, aphc_pkg::REG_OFFSET, aphc_pkg::CLS_MOVE, aphc_pkg::MODE_IDXN, 4'h2, 1);
        rdChk("stall count", aphc_pkg::OFF_STCNT, 32'h3);
        hz(aphc_pkg::CLS_MOVE, aphc_pkg::REG_OFFSET, aphc_pkg::CLS_MOVE, aphc_pkg::MODE_POSTINC, 4'h2, 0);
        hz(aphc_pkg::CLS_MOVE, aphc_pkg::REG_PTR1, aphc_pkg::CLS_MOVE, aphc_pkg::MODE_NONE, 4'h1, 0);
        hz(aphc_pkg::CLS_MOVE, aphc_pkg::REG_PTR1, aphc_pkg::CLS_MOVE, aphc_pkg::MODE_IDXIMM, 4'h1, 0);
        hz(aphc_pkg::CLS_MOVE, aphc_pkg::REG_STACK, aphc_pkg::CLS_MOVE, aphc_pkg::MODE_IDXIMM, 4'h5, 0);
        hz(aphc_pkg::CLS_BFTEST, aphc_pkg::REG_NONE, aphc_pkg::CLS_MOVE, aphc_pkg::MODE_POSTN, 4'h2, 0);
        hz(aphc_pkg::CLS_BITBR, aphc_pkg::REG_NONE, aphc_pkg::CLS_MOVE, aphc_pkg::MODE_POSTN, 4'h2, 0);
        wb(1'b1, aphc_pkg::OFF_HZST, 32'h7);
        hz(aphc_pkg::CLS_MOVE, aphc_pkg::REG_MODULO, aphc_pkg::CLS_MOVE, aphc_pkg::MODE_POSTDEC, 4'h0, 0);
        rdChk("modulo hazard flag", aphc_pkg::OFF_HZST, 32'h1);
        wb(1'b1, aphc_pkg::OFF_HZST, 32'h7);
        hz(aphc_pkg::CLS_MOVE, aphc_pkg::REG_PTR1, aphc_pkg::CLS_MOVE, aphc_pkg::MODE_POSTINC, 4'h1, 0);
        rdChk("pointer hazard flag", aphc_pkg::OFF_HZST, 32'h1);
        wb(1'b1, aphc_pkg::OFF_HZST, 32'h7);
        pm.setOps(aphc_pkg::BF_SET, 16'h0007, 13'h2, 16'h0040, 16'h0030);
        hz(aphc_pkg::CLS_BFMOD, aphc_pkg::REG_OFFSET, aphc_pkg::CLS_MOVE, aphc_pkg::MODE_POSTN, 4'h2, 0);
        rdChk("bit-field hazard flag", aphc_pkg::OFF_HZST, 32'h2);
        wb(1'b1, aphc_pkg::OFF_HZST, 32'h7);
        hz(aphc_pkg::CLS_MOVE, aphc_pkg::REG_STACK, aphc_pkg::CLS_CALL, aphc_pkg::MODE_NONE, 4'h5, 0);
        rdChk("call hazard flag", aphc_pkg::OFF_HZST, 32'h4);
        wb(1'b1, aphc_pkg::OFF_CTRL, 32'h0);
        hz(aphc_pkg::CLS_MOVE, aphc_pkg::REG_OFFSET, aphc_pkg::CLS_MOVE, aphc_pkg::MODE_POSTN, 4'h2, 0);
        wb(1'b1, aphc_pkg::OFF_CTRL, 32'h1);
    endtask
    task automatic tStatus();
        pm.setOps(aphc_pkg::BF_SET, 16'h0200, 13'h2, 16'h0040, 16'h0030);
        pm.idle(1);
        pm.issue(aphc_pkg::CLS_BFMOD, aphc_pkg::MODE_NONE, 4'h0, aphc_pkg::REG_STATUS, n);
        pm.idle(3);
        rdChk("sr after set", aphc_pkg::OFF_SR, 32'h0200);
        chk("loop flag set", 1, loopActive);
        pm.setOps(aphc_pkg::BF_CHG, 16'h0200, 13'h2, 16'h0040, 16'h0030);
        pm.issue(aphc_pkg::CLS_BFMOD, aphc_pkg::MODE_NONE, 4'h0, aphc_pkg::REG_STATUS, n);
        pm.idle(3);
        rdChk("sr after clear", aphc_pkg::OFF_SR, 32'h0);
    endtask
    task automatic tLoop();
        int i;
        pm.issue(aphc_pkg::CLS_LOOP, aphc_pkg::MODE_NONE, 4'h0, aphc_pkg::REG_NONE, n);
        pm.idle(3);
        chk("loop started", 1, loopActive);
        rdChk("loop end", aphc_pkg::OFF_LA, 32'h0040);
        rdChk("stack top", aphc_pkg::OFF_LSTK, 32'h0030);
        pm.fetch(16'h0040);
        for (i = 0; i < 4; i++) begin
            @(negedge clock);
            if (loopBranch === 1'b1) break;
        end
        chk("loop branch", 1, loopBranch);
        chk("loop target", 32'h0030, loopTarget);
        @(posedge clock);
        rdChk("count after pass", aphc_pkg::OFF_LC, 32'h1);
        rdChk("last fetch pc", aphc_pkg::OFF_PC, 32'h0040);
        pm.fetch(16'h0040);
        pm.idle(3);
        chk("loop ended", 0, loopActive);
        // Clear write-back lands on the cycle after the loop decode
        pm.setOps(aphc_pkg::BF_CLR, 16'h0200, 13'h8, 16'h0050, 16'h0038);
        pm.idle(1);
        pm.issue(aphc_pkg::CLS_BFMOD, aphc_pkg::MODE_NONE, 4'h0, aphc_pkg::REG_STATUS, n);
        pm.issue(aphc_pkg::CLS_LOOP, aphc_pkg::MODE_NONE, 4'h0, aphc_pkg::REG_NONE, n);
        pm.idle(4);
        chk("stale write-back", 0, loopActive);
        rdChk("stale loop end", aphc_pkg::OFF_LA, 32'h0050);
    endtask
    // ======================================================================
    // Main sequence
    initial begin
        {cyc, stb, we, adr, wdat, sel} <= '0;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        tRegs();
        tHazards();
        tStatus();
        tLoop();
        giveVerdict();
    end
endmodule
